// File: verilog/mss_cfg.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * motor startup sequencer.
 * Assumes inclusion by bare name from the sequencer's package and module.
 */
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

// Register byte offsets on the Wishbone bus.
`define MSS_OFS_CTRL 8'h00
`define MSS_OFS_HOLD 8'h04
`define MSS_OFS_RAMPU 8'h08
`define MSS_OFS_ACCEL 8'h0c
`define MSS_OFS_STAT 8'h10

// Control register bits, write only, self clearing.
`define MSS_CTRL_START 0
`define MSS_CTRL_STOP 1

// Hold register fields.
`define MSS_HOLD_COEF_LSB 0
`define MSS_HOLD_DUTY_LSB 8
`define MSS_HOLD_RAMP_LSB 16

// Ramp-up register fields.
`define MSS_RAMPU_FREQ_LSB 0
`define MSS_RAMPU_CUR_LSB 16

// Status register fields.
`define MSS_STAT_PHASE_LSB 0
`define MSS_STAT_FREQ_LSB 16

// Reset values of the settings.
`define MSS_RST_HOLD_COEF 6'h05
`define MSS_RST_DUTY 4'h4
`define MSS_RST_RAMP 4'h8
`define MSS_RST_FCUR 5'h04
`define MSS_RST_HANDOVER 16'h0100
`define MSS_RST_ACCEL 16'h0001

// Timing: PWM period in ns, clock period in ns, hold unit in PWM periods.
`define MSS_PWM_NS 50000
`define MSS_CLK_NS 10
`define MSS_HOLD_UNIT 2048

`endif

// File: verilog/mss_pkg.sv
/*
 * Types shared by the motor startup sequencer.
 * Assumes mss_cfg.svh is on the include path.
 */
`include "mss_cfg.svh"

package mss_pkg;

    // Startup phases in the order they run.
    typedef enum logic [1:0] {
        MSS_IDLE,
        MSS_ALIGN,
        MSS_ACCEL,
        MSS_CLOSED
    } mss_phase_t;

    // Startup settings as held by the register file.
    typedef struct packed {
        logic [5:0] hold_coef;
        logic [3:0] align_duty_setting;
        logic [3:0] ramp_code;
        logic [4:0] forced_commutation_current;
        logic [15:0] handover_frequency;
        logic [15:0] accel_step;
    } mss_cfg_t;

    // Drive commands toward the power stage.
    typedef struct packed {
        logic [7:0] align_duty;
        logic [4:0] current_ref;
        logic [15:0] frequency;
        logic closed_loop;
    } mss_drive_t;

endpackage

// File: verilog/mss_seq.sv
/*
 * Motor startup sequencer with a classic Wishbone register slave.
 * Assumes a 100 MHz clock, synchronous reset, and a power stage that turns
 * the drive command struct into PWM and current-loop action.
 */
// Our own choices: the Wishbone register port and the address map.
// Overview of operation
// - Hold coefficient 0 to 63, step one, reset value 5, sets hold length.
// - Hold length follows from coefficient times a fixed count of PWM periods.
// - Hold excitation uses a fixed duty, independent of supply voltage.
// - Hold duty code steps of 1.5 percent, 1.5 to 22.9, default 6.1; the code makes each step 16/256 of align_duty, 6.25 percent, default 25.
// - Hold duty rises along a slope over the selected ramp fraction.
// - Once rotating, frequency rises automatically up to the handover frequency.
// - At handover frequency the block switches to closed-loop frequency control.
// - Forced commutation regulates current to the selected current code.
// - Forced commutation starts directly when the hold phase finishes.
`timescale 1ns/10ps
`default_nettype none
`include "mss_cfg.svh"

module mss_seq #(
    parameter int unsigned PWM_CYCLES = `MSS_PWM_NS / `MSS_CLK_NS,
    parameter int unsigned HOLD_UNIT = `MSS_HOLD_UNIT
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Power stage commands.
    output mss_pkg::mss_phase_t phase_o,
    output mss_pkg::mss_drive_t drive_o
);
    import mss_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Merges write data into a word under the byte enables.
    function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Scales a hold length by a sixteenth-step fraction.
    function automatic logic [17:0] frac16(input logic [17:0] len, input logic [3:0] code);
        logic [21:0] p;
        p = len * code;
        return p[21:4];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file and bus slave.

    mss_cfg_t cfg, next_cfg;
    logic [31:0] next_dat;
    logic next_ack, start, next_start, stop, next_stop;
    logic [31:0] hold_w, rampu_w, accel_w;
    logic hit;

    assign hit = cyc_i && stb_i && !ack_o;
    assign hold_w = {12'h000, cfg.ramp_code, 4'h0, cfg.align_duty_setting, 2'h0, cfg.hold_coef};
    assign rampu_w = {11'h000, cfg.forced_commutation_current, cfg.handover_frequency};
    assign accel_w = {16'h0000, cfg.accel_step};

    // Ack comes one cycle after the request and drops the cycle after;
    // unmapped addresses are acked, read zero and ignore writes.
    always_comb begin
        logic [31:0] w;
        w = 32'h0000_0000;
        next_cfg = cfg;
        next_ack = hit;
        next_dat = dat_o;
        next_start = 1'b0;
        next_stop = 1'b0;
        if (hit) begin
            next_dat = 32'h0000_0000;
            unique case (adr_i)
                `MSS_OFS_HOLD: next_dat = hold_w;
                `MSS_OFS_RAMPU: next_dat = rampu_w;
                `MSS_OFS_ACCEL: next_dat = accel_w;
                `MSS_OFS_STAT: next_dat = {drive_o.frequency, 14'h0000, phase_o};
                default: next_dat = 32'h0000_0000;
            endcase
        end
        if (hit && we_i) begin
            unique case (adr_i)
                `MSS_OFS_CTRL: begin
                    w = wr_merge(32'h0000_0000, dat_i, sel_i);
                    next_start = w[`MSS_CTRL_START];
                    next_stop = w[`MSS_CTRL_STOP];
                end
                `MSS_OFS_HOLD: begin
                    w = wr_merge(hold_w, dat_i, sel_i);
                    next_cfg.hold_coef = w[`MSS_HOLD_COEF_LSB +: 6];
                    next_cfg.align_duty_setting = w[`MSS_HOLD_DUTY_LSB +: 4];
                    next_cfg.ramp_code = w[`MSS_HOLD_RAMP_LSB +: 4];
                end
                `MSS_OFS_RAMPU: begin
                    w = wr_merge(rampu_w, dat_i, sel_i);
                    next_cfg.handover_frequency = w[`MSS_RAMPU_FREQ_LSB +: 16];
                    next_cfg.forced_commutation_current = w[`MSS_RAMPU_CUR_LSB +: 5];
                end
                `MSS_OFS_ACCEL: begin
                    w = wr_merge(accel_w, dat_i, sel_i);
                    next_cfg.accel_step = w[15:0];
                end
                default: next_cfg = cfg;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg.hold_coef <= `MSS_RST_HOLD_COEF;
            cfg.align_duty_setting <= `MSS_RST_DUTY;
            cfg.ramp_code <= `MSS_RST_RAMP;
            cfg.forced_commutation_current <= `MSS_RST_FCUR;
            cfg.handover_frequency <= `MSS_RST_HANDOVER;
            cfg.accel_step <= `MSS_RST_ACCEL;
            dat_o <= 32'h0000_0000;
            ack_o <= 1'b0;
            start <= 1'b0;
            stop <= 1'b0;
        end else begin
            cfg <= next_cfg;
            dat_o <= next_dat;
            ack_o <= next_ack;
            start <= next_start;
            stop <= next_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM period timebase; all startup timing counts whole PWM periods.

    logic [15:0] pwm_cnt, next_pwm_cnt;
    logic tick;

    assign tick = (pwm_cnt == 16'(PWM_CYCLES - 1));

    always_comb begin
        next_pwm_cnt = tick ? 16'h0000 : pwm_cnt + 16'h0001;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_cnt <= 16'h0000;
        end else begin
            pwm_cnt <= next_pwm_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Startup sequencer.

    mss_phase_t next_phase;
    mss_drive_t next_drive;
    logic [17:0] hold_cnt, next_hold_cnt, hold_len, ramp_len, acc, next_acc;
    logic [7:0] duty_target;

    assign hold_len = 18'(cfg.hold_coef * HOLD_UNIT);
    assign ramp_len = frac16(hold_len, cfg.ramp_code);
    assign duty_target = {cfg.align_duty_setting, 4'h0};

    // Settings are read live, so writes while running steer the sequence;
    // software is expected to write them only at standstill.
    always_comb begin
        logic [17:0] sum;
        sum = acc + 18'(duty_target);
        next_phase = phase_o;
        next_drive = drive_o;
        next_hold_cnt = hold_cnt;
        next_acc = acc;
        unique case (phase_o)
            MSS_IDLE: begin
                next_drive = '0;
                if (start) begin
                    next_hold_cnt = 18'h00000;
                    next_acc = 18'h00000;
                    if (cfg.hold_coef == 6'h00) begin
                        next_phase = MSS_ACCEL;
                        next_drive.current_ref = cfg.forced_commutation_current;
                    end else begin
                        next_phase = MSS_ALIGN;
                    end
                end
            end
            MSS_ALIGN: begin
                if (tick) begin
                    next_hold_cnt = hold_cnt + 18'h00001;
                    // Fractional accumulator spreads the duty rise over the ramp.
                    if (drive_o.align_duty < duty_target) begin
                        if (sum >= ramp_len) begin
                            next_drive.align_duty = drive_o.align_duty + 8'h01;
                            next_acc = sum - ramp_len;
                        end else begin
                            next_acc = sum;
                        end
                    end else begin
                        next_drive.align_duty = duty_target;
                    end
                    if (hold_cnt == hold_len - 18'h00001) begin
                        next_phase = MSS_ACCEL;
                        next_drive.align_duty = 8'h00;
                        next_drive.current_ref = cfg.forced_commutation_current;
                    end
                end
            end
            MSS_ACCEL: begin
                next_drive.current_ref = cfg.forced_commutation_current;
                if (drive_o.frequency >= cfg.handover_frequency) begin
                    next_phase = MSS_CLOSED;
                    next_drive.closed_loop = 1'b1;
                end else if (tick) begin
                    if (cfg.handover_frequency - drive_o.frequency > cfg.accel_step) begin
                        next_drive.frequency = drive_o.frequency + cfg.accel_step;
                    end else begin
                        next_drive.frequency = cfg.handover_frequency;
                    end
                end
            end
            MSS_CLOSED: begin
                next_drive.closed_loop = 1'b1;
            end
        endcase
        if (stop) begin
            next_phase = MSS_IDLE;
            next_drive = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_o <= MSS_IDLE;
            drive_o <= '0;
            hold_cnt <= 18'h00000;
            acc <= 18'h00000;
        end else begin
            phase_o <= next_phase;
            drive_o <= next_drive;
            hold_cnt <= next_hold_cnt;
            acc <= next_acc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_start_idle;
        phase_o == MSS_IDLE && start && !stop;
    endsequence

    sequence s_hold_done;
        phase_o == MSS_ALIGN && tick && !stop && hold_cnt == hold_len - 18'h00001;
    endsequence

    a_hold_skip: assert property (s_start_idle ##0 cfg.hold_coef == 6'h00 |=>
        phase_o == MSS_ACCEL) else $error("zero hold did not skip to accel");
    a_hold_entry: assert property (s_start_idle ##0 cfg.hold_coef != 6'h00 |=>
        phase_o == MSS_ALIGN && hold_cnt == 18'h00000) else $error("hold not entered");
    a_hold_exit: assert property (s_hold_done |=> phase_o == MSS_ACCEL &&
        drive_o.current_ref == $past(cfg.forced_commutation_current))
        else $error("accel not entered at end of hold");
    a_hold_length: assert property (phase_o == MSS_ALIGN && !stop |->
        hold_cnt < hold_len) else $error("hold ran past its length");
    a_duty_ceiling: assert property (phase_o == MSS_ALIGN |->
        drive_o.align_duty <= duty_target) else $error("hold duty above setting");
    a_duty_slope: assert property (phase_o == MSS_ALIGN && !stop ##1 phase_o == MSS_ALIGN |->
        drive_o.align_duty - $past(drive_o.align_duty) <= 8'h01 ||
        drive_o.align_duty == duty_target) else $error("hold duty stepped");
    a_freq_rise: assert property (phase_o == MSS_ACCEL && tick && !stop &&
        drive_o.frequency < cfg.handover_frequency |=> drive_o.frequency > $past(drive_o.frequency))
        else $error("frequency did not rise");
    a_handover_switch: assert property (phase_o == MSS_ACCEL && !stop &&
        drive_o.frequency >= cfg.handover_frequency |=> phase_o == MSS_CLOSED ##0
        drive_o.closed_loop) else $error("no closed-loop switch at handover");
    a_order_kept: assert property (phase_o == MSS_CLOSED |=>
        phase_o == MSS_CLOSED || phase_o == MSS_IDLE) else $error("phase order broken");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// File: verification/mss_motor_model.sv
/*
 * Behavioural motor seen through the power stage of the startup sequencer.
 * Assumes the sequencer's drive command struct and a single clock.
 */
`timescale 1ns/10ps
`default_nettype none

module mss_motor_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Drive command from the sequencer.
    input wire mss_pkg::mss_drive_t drive_i,
    // Rotor state.
    output logic [31:0] angle_o,
    output logic locked_o
);
    import mss_pkg::*;

    // The rotor turns only while a forced current is applied; unpowered it stops at once and holds its angle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            angle_o <= 32'h0;
            locked_o <= 1'b0;
        end else begin
            if (drive_i.current_ref != 5'h0) begin
                angle_o <= angle_o + {16'h0, drive_i.frequency};
            end
            locked_o <= (drive_i.align_duty != 8'h0); // Held at its initial position.
        end
    end
endmodule

`default_nettype wire

// File: verification/testbench.sv
/*
 * Self-checking bench of the motor startup sequencer.
 * Assumes mss_pkg, mss_seq and the motor model are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mss_cfg.svh"

module testbench;
    import mss_pkg::*;
    // Short timebase so a full startup in the tests takes about a hundred cycles.
    localparam int PWM = 8;
    localparam int UNIT = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    mss_phase_t phase_o;
    mss_drive_t drive_o;
    logic [31:0] angle;
    logic locked;
    logic [31:0] rd;
    // Byte enables of the next bus request; full word unless a scenario narrows it.
    logic [3:0] wsel = 4'hf;
    mss_phase_t last_phase = MSS_IDLE;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    mss_seq #(.PWM_CYCLES(PWM), .HOLD_UNIT(UNIT)) i_mss_seq (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .phase_o(phase_o), .drive_o(drive_o));
    mss_motor_model i_mss_motor_model (
        .clk_i(clk_i), .rst_i(rst_i), .drive_i(drive_o), .angle_o(angle), .locked_o(locked));

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, bus and closing helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic ok(input logic cond);
        check({31'h0, cond}, 32'h1);
    endtask

    task automatic ph(input mss_phase_t want);
        check({30'h0, phase_o}, {30'h0, want});
    endtask

    task automatic wrap_up();
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Classic single cycle; ack is sampled before the edge's own updates land.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        sel_i <= wsel;
        dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Legal phase steps: forward by one, IDLE may skip the hold, stop returns to IDLE.
    function automatic logic legal(input mss_phase_t a, input mss_phase_t b);
        return b == MSS_IDLE || (a == MSS_IDLE && b == MSS_ACCEL) || int'(b) == int'(a) + 1;
    endfunction

    // Phase order watcher, active for the whole run.
    always @(posedge clk_i) begin
        if (!rst_i && phase_o !== last_phase) ok(legal(last_phase, phase_o));
        last_phase <= phase_o;
    end

    // Hang guard: far above the few hundred cycles the tests need.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_defaults();
        ph(MSS_IDLE);
        wb(1'b0, `MSS_OFS_HOLD, 32'h0);
        check(rd, 32'h0008_0405);
        wb(1'b0, `MSS_OFS_ACCEL, 32'h0);
        check(rd, 32'h0000_0001);
        // Only the duty byte lane is enabled, so the other fields must keep their defaults.
        wsel = 4'h2;
        wb(1'b1, `MSS_OFS_HOLD, 32'hffff_0cff);
        wsel = 4'hf;
        wb(1'b0, `MSS_OFS_HOLD, 32'h0);
        check(rd, 32'h0008_0c05);
        wb(1'b0, `MSS_OFS_RAMPU, 32'h0);
        check(rd, 32'h0004_0100);
        wb(1'b1, `MSS_OFS_STAT, 32'hffff_ffff);
        wb(1'b1, 8'h20, 32'h1234_5678);
        wb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, `MSS_OFS_STAT, 32'h0);
        check(rd, 32'h0);
        $display("t_defaults done");
    endtask

    task automatic t_full_start();
        int n;
        int bad;
        logic [15:0] pf;
        logic [7:0] pd;
        int held;
        n = 1;
        bad = 0;
        pd = 8'h0;
        held = 0;
        wb(1'b1, `MSS_OFS_HOLD, 32'h0008_0f02);
        wb(1'b1, `MSS_OFS_RAMPU, 32'h001f_0010);
        wb(1'b1, `MSS_OFS_ACCEL, 32'h4);
        wb(1'b1, `MSS_OFS_CTRL, 32'h1);
        ph(MSS_ALIGN);
        while (phase_o == MSS_ALIGN && n < 200) begin
            if (drive_o.align_duty < pd || drive_o.align_duty > pd + 8'h1) bad++;
            if (drive_o.current_ref !== 5'h0 || drive_o.closed_loop !== 1'b0) bad++;
            if (locked === 1'b1) held++;
            pd = drive_o.align_duty;
            @(posedge clk_i);
            n++;
        end
        check(bad, 0);
        ok(pd > 8'h0 && pd <= 8'hf0);
        ok(held > 0);
        ok(n >= (2 * UNIT - 1) * PWM + 2 && n <= 2 * UNIT * PWM + 1);
        ph(MSS_ACCEL);
        check(32'(drive_o.current_ref), 32'h1f);
        check(32'(drive_o.align_duty), 32'h0);
        pf = drive_o.frequency;
        n = 0;
        while (phase_o == MSS_ACCEL && n < 100) begin
            if (drive_o.frequency < pf || drive_o.frequency > pf + 16'h4) bad++;
            if (drive_o.frequency > 16'h10 || drive_o.current_ref !== 5'h1f) bad++;
            pf = drive_o.frequency;
            @(posedge clk_i);
            n++;
        end
        check(bad, 0);
        ph(MSS_CLOSED);
        check(32'(drive_o.closed_loop), 32'h1);
        check(32'(drive_o.frequency), 32'h10);
        ok(locked == 1'b0);
        ok(angle != 32'h0);
        wb(1'b1, `MSS_OFS_CTRL, 32'h1);
        wb(1'b0, `MSS_OFS_STAT, 32'h0);
        check(rd, 32'h0010_0003);
        wb(1'b1, `MSS_OFS_CTRL, 32'h2);
        ph(MSS_IDLE);
        check(32'(drive_o), 32'h0);
        $display("t_full_start done");
    endtask

    task automatic t_skip_and_stop();
        int n;
        n = 0;
        wb(1'b1, `MSS_OFS_HOLD, 32'h0008_0f00);
        wb(1'b1, `MSS_OFS_CTRL, 32'h1);
        ph(MSS_ACCEL);
        check(32'(drive_o.current_ref), 32'h1f);
        while (phase_o != MSS_CLOSED && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        ph(MSS_CLOSED);
        wb(1'b1, `MSS_OFS_CTRL, 32'h2);
        wb(1'b1, `MSS_OFS_CTRL, 32'h3);
        repeat (3) @(posedge clk_i);
        ph(MSS_IDLE);
        wb(1'b1, `MSS_OFS_RAMPU, 32'h0004_0000);
        wb(1'b1, `MSS_OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
        ph(MSS_CLOSED);
        check(32'(drive_o.closed_loop), 32'h1);
        check(32'(drive_o.current_ref), 32'h04);
        wb(1'b1, `MSS_OFS_CTRL, 32'h2);
        ph(MSS_IDLE);
        $display("t_skip_and_stop done");
    endtask

    // Main sequence: reset for two cycles, then the scenarios.
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_defaults();
        t_full_start();
        t_skip_and_stop();
        wrap_up();
    end
endmodule

`default_nettype wire
